/* hdl/ddc_pkg.sv */
// Shared constants and helpers for the oscillator, synchronisation and decimation datapath.
`default_nettype none
package ddc_pkg;
  localparam int CHANNELS = 2;
  localparam int OSC_COUNT = 4;
  localparam int FREQ_W = 32;
  localparam int PHASE_OFS_W = 16;
  localparam int RDIV_W = 16;
  localparam int SEL_W = 2;
  localparam int SAMPLE_W = 12;
  localparam int OUT_W = 15;
  localparam int SINE_W = 16;
  localparam int ACC_W = 40;
  localparam int STAGES = 5;
  localparam int HB_TAPS = 7;
  localparam int RATIONAL_FRAC_BITS = 26;
  localparam int RAT_TOP_W = FREQ_W - RATIONAL_FRAC_BITS;
  localparam int LUT_ADDR_W = 5;
  localparam int MIX_SHIFT = 12;
  localparam int CLK_RATE_HZ = 20000000;
  localparam logic [LUT_ADDR_W-1:0] LUT_QUARTER = 5'h08;
  localparam logic [RDIV_W-1:0] RDIV_BASIC = 16'h0000;
  localparam logic [2:0] DECIM_BYPASS = 3'h0;
  localparam logic [2:0] DECIM_4 = 3'h1;
  localparam logic [2:0] DECIM_8 = 3'h2;
  localparam logic [2:0] DECIM_16 = 3'h3;
  localparam logic [2:0] DECIM_32 = 3'h4;
  localparam logic [2:0] STAGE_NONE = 3'h5;
  // Stage order: stage5, stage10, stage20, stage40, stage80.
  localparam int STAGE_OUTER [STAGES] = '{-1, -65, -65, -65, -65};
  localparam int STAGE_INNER [STAGES] = '{9, 577, 577, 577, 577};
  localparam int STAGE_CENTER [STAGES] = '{16, 1024, 1024, 1024, 1024};
  localparam int STAGE_SHIFT [STAGES] = '{5, 11, 11, 11, 11};

  // Index of the first stage in use; STAGE_NONE means bypass.
  function automatic logic [2:0] first_stage(input logic [2:0] mode);
    case (mode)
      DECIM_4: first_stage = 3'h3;
      DECIM_8: first_stage = 3'h2;
      DECIM_16: first_stage = 3'h1;
      DECIM_32: first_stage = 3'h0;
      default: first_stage = STAGE_NONE;
    endcase
  endfunction

  // Round to nearest, ties to even, then saturate to the output width.
  function automatic logic signed [OUT_W-1:0] round_sat(input logic signed [ACC_W-1:0] v, input int sh);
    logic signed [ACC_W-1:0] q;
    logic [ACC_W-1:0] rem;
    logic [ACC_W-1:0] half;
    logic signed [ACC_W-1:0] lim;
    q = v >>> sh;
    rem = v & ((40'h1 << sh) - 40'h1);
    half = 40'h1 << (sh - 1);
    lim = 40'sh1 <<< (OUT_W - 1);
    if (rem > half || (rem == half && q[0])) begin
      q = q + 40'sh1;
    end
    if (q >= lim) begin
      round_sat = 15'sh3fff;
    end else if (q < -lim) begin
      round_sat = 15'sh4000;
    end else begin
      round_sat = q[OUT_W-1:0];
    end
  endfunction

  // Coarse 32-point sine; a quarter wave is stored and mirrored.
  function automatic logic signed [SINE_W-1:0] sine_lut(input logic [LUT_ADDR_W-1:0] idx);
    logic [3:0] k;
    logic [SINE_W-1:0] mag;
    k = idx[3] ? (4'h8 - {1'b0, idx[2:0]}) : {1'b0, idx[2:0]};
    case (k)
      4'h0: mag = 16'h0000;
      4'h1: mag = 16'h18f9;
      4'h2: mag = 16'h30fb;
      4'h3: mag = 16'h471c;
      4'h4: mag = 16'h5a82;
      4'h5: mag = 16'h6a6d;
      4'h6: mag = 16'h7641;
      4'h7: mag = 16'h7d89;
      default: mag = 16'h7fff;
    endcase
    sine_lut = idx[4] ? -$signed(mag) : $signed(mag);
  endfunction
endpackage
`default_nettype wire

/* hdl/hb_stage.sv */
// Folded half-band decimate-by-two stage for one complex stream.
`default_nettype none
module hb_stage #(
  parameter int C_OUTER = -1,
  parameter int C_INNER = 9,
  parameter int C_CENTER = 16,
  parameter int SHIFT = 5
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Input stream
  input wire logic in_valid_i,
  input wire logic signed [ddc_pkg::OUT_W-1:0] in_i_i,
  input wire logic signed [ddc_pkg::OUT_W-1:0] in_q_i,
  // Output stream
  output logic out_valid_o,
  output logic signed [ddc_pkg::OUT_W-1:0] out_i_o,
  output logic signed [ddc_pkg::OUT_W-1:0] out_q_o
);
  import ddc_pkg::*;
  logic signed [OUT_W-1:0] tap_i_reg [HB_TAPS];
  logic signed [OUT_W-1:0] tap_q_reg [HB_TAPS];
  logic phase_reg;
  logic go_reg;
  logic out_valid_reg;
  logic signed [OUT_W-1:0] out_i_reg;
  logic signed [OUT_W-1:0] out_q_reg;

  // Mirrored taps share one multiplier; the full-precision sum is rounded only here.
  function automatic logic signed [OUT_W-1:0] fold(input logic signed [OUT_W-1:0] t [HB_TAPS]);
    logic signed [ACC_W-1:0] acc;
    acc = ACC_W'(C_OUTER) * (ACC_W'(t[0]) + ACC_W'(t[HB_TAPS-1]))
        + ACC_W'(C_INNER) * (ACC_W'(t[2]) + ACC_W'(t[HB_TAPS-3]))
        + ACC_W'(C_CENTER) * ACC_W'(t[HB_TAPS/2]);
    fold = round_sat(acc, SHIFT);
  endfunction

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int n = 0; n < HB_TAPS; n++) begin
        tap_i_reg[n] <= '0;
        tap_q_reg[n] <= '0;
      end
      phase_reg <= 1'b0;
      go_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_i_reg <= '0;
      out_q_reg <= '0;
    end else begin
      go_reg <= in_valid_i & phase_reg;
      out_valid_reg <= go_reg;
      if (in_valid_i) begin
        tap_i_reg[0] <= in_i_i;
        tap_q_reg[0] <= in_q_i;
        for (int n = 1; n < HB_TAPS; n++) begin
          tap_i_reg[n] <= tap_i_reg[n-1];
          tap_q_reg[n] <= tap_q_reg[n-1];
        end
        phase_reg <= ~phase_reg;
      end
      if (go_reg) begin
        out_i_reg <= fold(tap_i_reg);
        out_q_reg <= fold(tap_q_reg);
      end
    end
  end

  assign out_valid_o = out_valid_reg;
  assign out_i_o = out_i_reg;
  assign out_q_o = out_q_reg;
endmodule
`default_nettype wire

/* hdl/nco_sync_and_decimation_chain.sv */
// Oscillators, phase synchronisation and half-band decimation chain for two channels.
`default_nettype none
module nco_sync_and_decimation_chain (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Converter samples
  input wire logic signed [ddc_pkg::SAMPLE_W-1:0] sample_chan_a_i,
  input wire logic signed [ddc_pkg::SAMPLE_W-1:0] sample_chan_b_i,
  // Oscillator settings
  input wire logic [ddc_pkg::OSC_COUNT-1:0][ddc_pkg::FREQ_W-1:0] freq_word_chan_a_i,
  input wire logic [ddc_pkg::OSC_COUNT-1:0][ddc_pkg::FREQ_W-1:0] freq_word_chan_b_i,
  input wire logic [ddc_pkg::OSC_COUNT-1:0][ddc_pkg::PHASE_OFS_W-1:0] phase_offset_chan_a_i,
  input wire logic [ddc_pkg::OSC_COUNT-1:0][ddc_pkg::PHASE_OFS_W-1:0] phase_offset_chan_b_i,
  input wire logic [ddc_pkg::RDIV_W-1:0] rational_divisor_i,
  // Oscillator selection
  input wire logic osc_select_source_i,
  input wire logic [ddc_pkg::SEL_W-1:0] osc_select_reg_a_i,
  input wire logic [ddc_pkg::SEL_W-1:0] osc_select_reg_b_i,
  input wire logic [ddc_pkg::SEL_W-1:0] osc_select_pins_a_i,
  input wire logic [ddc_pkg::SEL_W-1:0] osc_select_pins_b_i,
  // Synchronisation control and link signals
  input wire logic link_sync_enable_i,
  input wire logic next_sysref_arm_i,
  input wire logic link_enable_i,
  input wire logic encoding_64b66b_i,
  input wire logic sync_i,
  input wire logic sysref_i,
  // Decimation
  input wire logic [2:0] decim_sel_i,
  // Output samples
  output logic out_valid_o,
  output logic out_complex_o,
  output logic signed [ddc_pkg::OUT_W-1:0] out_i_chan_a_o,
  output logic signed [ddc_pkg::OUT_W-1:0] out_q_chan_a_o,
  output logic signed [ddc_pkg::OUT_W-1:0] out_i_chan_b_o,
  output logic signed [ddc_pkg::OUT_W-1:0] out_q_chan_b_o,
  // Status
  output logic sync_armed_o,
  output logic phase_deterministic_o,
  output logic nco_sync_pulse_o,
  output logic code_group_sync_start_o
);
  import ddc_pkg::*;

  typedef enum logic [1:0] {LINK_IDLE, LINK_WAIT_LOW, LINK_ARMED} link_state_t;

  logic [CHANNELS-1:0][OSC_COUNT-1:0][FREQ_W-1:0] freq_w;
  logic [CHANNELS-1:0][OSC_COUNT-1:0][FREQ_W-1:0] freq_reg;
  logic [CHANNELS-1:0][OSC_COUNT-1:0][PHASE_OFS_W-1:0] phase_w;
  logic [CHANNELS-1:0][OSC_COUNT-1:0][PHASE_OFS_W-1:0] phase_reg;
  logic [CHANNELS-1:0][OSC_COUNT-1:0][FREQ_W-1:0] acc_reg;
  logic [CHANNELS-1:0][OSC_COUNT-1:0][FREQ_W-1:0] acc_next;
  logic [CHANNELS-1:0][SEL_W-1:0] sel_reg_w;
  logic [CHANNELS-1:0][SEL_W-1:0] sel_pins_w;
  logic [CHANNELS-1:0][SEL_W-1:0] sel_reg_reg;
  logic [CHANNELS-1:0][SEL_W-1:0] sel_pins_reg;
  logic [CHANNELS-1:0][SEL_W-1:0] sel_w;
  logic [CHANNELS-1:0][SAMPLE_W-1:0] sample_w;
  logic [CHANNELS-1:0][SAMPLE_W-1:0] sample_reg;
  logic [RDIV_W-1:0] rdiv_reg;
  logic [RDIV_W-1:0] rcount_reg;
  logic [RDIV_W-1:0] rcount_next;
  logic sel_source_reg;
  logic link_sync_en_reg;
  logic arm_reg;
  logic arm_prev_reg;
  logic link_en_reg;
  logic enc64_reg;
  logic sync_reg;
  logic sysref_reg;
  logic sysref_prev_reg;
  logic [2:0] decim_reg;
  link_state_t link_state_reg;
  link_state_t link_state_next;
  logic link_sync_event;
  logic cgs_start;
  logic sysref_rise;
  logic arm_rise;
  logic sysref_event;
  logic sync_event;
  logic armed_reg;
  logic armed_next;
  logic det_reg;
  logic det_next;
  logic freq_changed;
  logic rational_wrap;
  logic sync_pulse_reg;
  logic cgs_reg;
  logic [2:0] first_w;
  logic bypass_w;
  logic mix_valid_reg;
  logic signed [CHANNELS-1:0][OUT_W-1:0] mix_i_reg;
  logic signed [CHANNELS-1:0][OUT_W-1:0] mix_q_reg;
  logic [CHANNELS-1:0] chain_valid_w;
  logic signed [CHANNELS-1:0][OUT_W-1:0] chain_i_w;
  logic signed [CHANNELS-1:0][OUT_W-1:0] chain_q_w;
  logic out_valid_reg;
  logic out_complex_reg;
  logic signed [CHANNELS-1:0][OUT_W-1:0] out_i_reg;
  logic signed [CHANNELS-1:0][OUT_W-1:0] out_q_reg;

  // Steps one accumulator; in rational mode the word error is cleared each divisor period.
  function automatic logic [FREQ_W-1:0] step_acc(input logic [FREQ_W-1:0] acc, input logic [FREQ_W-1:0] inc,
                                                 input logic snap);
    logic [FREQ_W-1:0] sum;
    logic [RAT_TOP_W-1:0] top;
    sum = acc + inc;
    top = sum[FREQ_W-1:RATIONAL_FRAC_BITS] + RAT_TOP_W'(sum[RATIONAL_FRAC_BITS-1]);
    step_acc = snap ? {top, {RATIONAL_FRAC_BITS{1'b0}}} : sum;
  endfunction

  assign freq_w = {freq_word_chan_b_i, freq_word_chan_a_i};
  assign phase_w = {phase_offset_chan_b_i, phase_offset_chan_a_i};
  assign sel_reg_w = {osc_select_reg_b_i, osc_select_reg_a_i};
  assign sel_pins_w = {osc_select_pins_b_i, osc_select_pins_a_i};
  assign sample_w = {sample_chan_b_i, sample_chan_a_i};

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      freq_reg <= '0;
      phase_reg <= '0;
      rdiv_reg <= RDIV_BASIC;
      sel_source_reg <= 1'b0;
      sel_reg_reg <= '0;
      sel_pins_reg <= '0;
      link_sync_en_reg <= 1'b0;
      arm_reg <= 1'b0;
      arm_prev_reg <= 1'b0;
      link_en_reg <= 1'b0;
      enc64_reg <= 1'b0;
      sync_reg <= 1'b1;
      sysref_reg <= 1'b0;
      sysref_prev_reg <= 1'b0;
      decim_reg <= DECIM_BYPASS;
      sample_reg <= '0;
    end else begin
      freq_reg <= freq_w;
      phase_reg <= phase_w;
      rdiv_reg <= rational_divisor_i;
      sel_source_reg <= osc_select_source_i;
      sel_reg_reg <= sel_reg_w;
      sel_pins_reg <= sel_pins_w;
      link_sync_en_reg <= link_sync_enable_i;
      arm_reg <= next_sysref_arm_i;
      arm_prev_reg <= arm_reg;
      link_en_reg <= link_enable_i;
      enc64_reg <= encoding_64b66b_i;
      sync_reg <= sync_i;
      sysref_reg <= sysref_i;
      sysref_prev_reg <= sysref_reg;
      decim_reg <= decim_sel_i;
      sample_reg <= sample_w;
    end
  end

  always_comb begin
    link_state_next = link_state_reg;
    link_sync_event = 1'b0;
    cgs_start = 1'b0;
    case (link_state_reg)
      LINK_IDLE: begin
        if (link_en_reg) begin
          link_state_next = LINK_WAIT_LOW;
        end
      end
      LINK_WAIT_LOW: begin
        if (!link_en_reg) begin
          link_state_next = LINK_IDLE;
        end else if (!sync_reg) begin
          link_state_next = LINK_ARMED;
          cgs_start = !enc64_reg;
        end
      end
      LINK_ARMED: begin
        if (!link_en_reg) begin
          link_state_next = LINK_IDLE;
        end else if (sync_reg) begin
          link_state_next = LINK_WAIT_LOW;
          link_sync_event = link_sync_en_reg;
        end
      end
      default: link_state_next = LINK_IDLE;
    endcase
  end

  assign sysref_rise = sysref_reg & ~sysref_prev_reg;
  assign arm_rise = arm_reg & ~arm_prev_reg;
  assign sysref_event = armed_reg & sysref_rise;
  assign armed_next = arm_rise | (armed_reg & ~sysref_event);
  assign sync_event = link_sync_event | sysref_event;
  assign freq_changed = freq_w != freq_reg;
  assign det_next = sync_event | (det_reg & ~freq_changed);
  assign rational_wrap = (rdiv_reg != RDIV_BASIC) && (rcount_reg == rdiv_reg - 16'h0001);
  assign rcount_next = (sync_event || rational_wrap || rdiv_reg == RDIV_BASIC) ? '0 : rcount_reg + 16'h0001;

  always_comb begin
    acc_next = acc_reg;
    for (int c = 0; c < CHANNELS; c++) begin
      for (int o = 0; o < OSC_COUNT; o++) begin
        acc_next[c][o] = sync_event ? '0 : step_acc(acc_reg[c][o], freq_reg[c][o], rational_wrap);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_state_reg <= LINK_IDLE;
      armed_reg <= 1'b0;
      det_reg <= 1'b0;
      rcount_reg <= '0;
      acc_reg <= '0;
      sync_pulse_reg <= 1'b0;
      cgs_reg <= 1'b0;
    end else begin
      link_state_reg <= link_state_next;
      armed_reg <= armed_next;
      det_reg <= det_next;
      rcount_reg <= rcount_next;
      acc_reg <= acc_next;
      sync_pulse_reg <= sync_event;
      cgs_reg <= cgs_start;
    end
  end

  assign first_w = first_stage(decim_reg);
  assign bypass_w = first_w == STAGE_NONE;

  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    logic [FREQ_W-1:0] phase_sum;
    logic [LUT_ADDR_W-1:0] lut_idx;
    logic signed [SINE_W-1:0] cos_w;
    logic signed [SINE_W-1:0] sin_w;
    logic signed [ACC_W-1:0] prod_i;
    logic signed [ACC_W-1:0] prod_q;
    logic [STAGES:0] sv;
    logic signed [STAGES:0][OUT_W-1:0] si;
    logic signed [STAGES:0][OUT_W-1:0] sq;

    assign sel_w[c] = sel_source_reg ? sel_pins_reg[c] : sel_reg_reg[c];
    assign phase_sum = acc_reg[c][sel_w[c]] + {phase_reg[c][sel_w[c]], {(FREQ_W - PHASE_OFS_W){1'b0}}};
    assign lut_idx = phase_sum[FREQ_W-1 -: LUT_ADDR_W];
    assign cos_w = sine_lut(lut_idx + LUT_QUARTER);
    assign sin_w = sine_lut(lut_idx);
    assign prod_i = $signed(sample_reg[c]) * cos_w;
    assign prod_q = $signed(sample_reg[c]) * sin_w;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        mix_i_reg[c] <= '0;
        mix_q_reg[c] <= '0;
      end else begin
        mix_i_reg[c] <= round_sat(prod_i, MIX_SHIFT);
        mix_q_reg[c] <= round_sat(prod_q, MIX_SHIFT);
      end
    end

    assign sv[0] = 1'b0;
    assign si[0] = '0;
    assign sq[0] = '0;
    for (genvar k = 0; k < STAGES; k++) begin : g_stage
      logic in_v;
      logic is_first;
      logic is_after;
      assign is_first = first_w == 3'(k);
      assign is_after = first_w < 3'(k);
      assign in_v = is_first ? mix_valid_reg : (is_after & sv[k]);
      hb_stage #(
        .C_OUTER(STAGE_OUTER[k]),
        .C_INNER(STAGE_INNER[k]),
        .C_CENTER(STAGE_CENTER[k]),
        .SHIFT(STAGE_SHIFT[k])
      ) u_stage (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(in_v),
        .in_i_i(is_first ? mix_i_reg[c] : si[k]),
        .in_q_i(is_first ? mix_q_reg[c] : sq[k]),
        .out_valid_o(sv[k+1]),
        .out_i_o(si[k+1]),
        .out_q_o(sq[k+1])
      );
    end
    assign chain_valid_w[c] = sv[STAGES];
    assign chain_i_w[c] = si[STAGES];
    assign chain_q_w[c] = sq[STAGES];
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mix_valid_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_complex_reg <= 1'b0;
      out_i_reg <= '0;
      out_q_reg <= '0;
    end else begin
      mix_valid_reg <= 1'b1;
      out_valid_reg <= bypass_w ? mix_valid_reg : chain_valid_w[0];
      out_complex_reg <= ~bypass_w;
      for (int c = 0; c < CHANNELS; c++) begin
        if (bypass_w) begin
          out_i_reg[c] <= OUT_W'($signed(sample_reg[c]));
          out_q_reg[c] <= '0;
        end else if (chain_valid_w[c]) begin
          out_i_reg[c] <= chain_i_w[c];
          out_q_reg[c] <= chain_q_w[c];
        end
      end
    end
  end

  assign out_valid_o = out_valid_reg;
  assign out_complex_o = out_complex_reg;
  assign out_i_chan_a_o = out_i_reg[0];
  assign out_q_chan_a_o = out_q_reg[0];
  assign out_i_chan_b_o = out_i_reg[1];
  assign out_q_chan_b_o = out_q_reg[1];
  assign sync_armed_o = armed_reg;
  assign phase_deterministic_o = det_reg;
  assign nco_sync_pulse_o = sync_pulse_reg;
  assign code_group_sync_start_o = cgs_reg;
endmodule
`default_nettype wire

/* testbench/nco_chk_assertions.sv */
// Port-level checker for the oscillator sync and decimation chain.
`default_nettype none
module nco_chk (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Watched inputs
  input wire logic signed [ddc_pkg::SAMPLE_W-1:0] sample_chan_a_i,
  input wire logic [ddc_pkg::OSC_COUNT-1:0][ddc_pkg::FREQ_W-1:0] freq_word_chan_a_i,
  input wire logic link_sync_enable_i,
  input wire logic link_enable_i,
  input wire logic encoding_64b66b_i,
  input wire logic sync_i,
  input wire logic sysref_i,
  input wire logic [2:0] decim_sel_i,
  // Watched outputs
  input wire logic out_valid_o,
  input wire logic out_complex_o,
  input wire logic signed [ddc_pkg::OUT_W-1:0] out_i_chan_a_o,
  input wire logic signed [ddc_pkg::OUT_W-1:0] out_q_chan_a_o,
  input wire logic sync_armed_o,
  input wire logic phase_deterministic_o,
  input wire logic nco_sync_pulse_o,
  input wire logic code_group_sync_start_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import ddc_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_bypass_data: assert property ((decim_sel_i == DECIM_BYPASS)[*3] |->
    out_valid_o && !out_complex_o && out_i_chan_a_o == OUT_W'($past(sample_chan_a_i, 2)) && out_q_chan_a_o == '0)
    else $error("bypass output wrong");
  a_decim_complex: assert property ((decim_sel_i != DECIM_BYPASS && decim_sel_i < STAGE_NONE)[*3] ##0 out_valid_o |->
    out_complex_o) else $error("decimated output not complex");
  a_by4_gap: assert property ((decim_sel_i == DECIM_4)[*8] ##0 out_valid_o |=> !out_valid_o [*3])
    else $error("by-4 strobe too close");
  a_pulse_single: assert property (nco_sync_pulse_o |=> !nco_sync_pulse_o)
    else $error("sync pulse too long");
  a_pulse_det: assert property (nco_sync_pulse_o |-> phase_deterministic_o)
    else $error("sync without phase status");
  a_freq_drop: assert property ($changed(freq_word_chan_a_i) |-> ##[1:2] !phase_deterministic_o)
    else $error("phase status kept after word change");
  a_sysref_sync: assert property (sync_armed_o && $rose(sysref_i) |-> ##[1:4] nco_sync_pulse_o)
    else $error("armed sysref edge missed");
  a_link_sync: assert property ((link_enable_i && link_sync_enable_i && !sync_i)[*4] ##1
    (link_enable_i && link_sync_enable_i && sync_i) |-> ##[1:4] nco_sync_pulse_o) else $error("link sync missed");
  a_cgs_start: assert property (link_enable_i[*4] ##0 (!encoding_64b66b_i && $fell(sync_i)) |->
    ##[1:4] code_group_sync_start_o) else $error("code group sync not started");
  a_cgs_quiet: assert property (encoding_64b66b_i[*4] |-> !code_group_sync_start_o)
    else $error("code group sync in 64b66b");
  c_complex: cover property (out_valid_o && out_complex_o);
  c_cgs: cover property (code_group_sync_start_o);
  c_sync: cover property (nco_sync_pulse_o);
endmodule
`default_nettype wire

/* testbench/rx_model.sv */
// Receiver and SYSREF source model driving the SYNC and SYSREF lines.
`default_nettype none
module rx_model (
  // Clock
  input wire logic ref_clk_i,
  // Commands
  input wire logic sync_low_i,
  input wire logic sysref_run_i,
  input wire logic sysref_shot_i,
  // Link lines
  output logic sync_o = 1'b1,
  output logic sysref_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] phase_reg = 4'h0;
  logic sync_low_reg = 1'b0;
  logic run_reg = 1'b0;
  logic shot_reg = 1'b0;
  // Commands are taken on the rising edge, since the bench changes them on the same falling edge the lines move on.
  always @(posedge ref_clk_i) begin
    sync_low_reg <= sync_low_i;
    run_reg <= sysref_run_i;
    shot_reg <= sysref_shot_i;
  end
  // SYNC idles high and falls low on command for all converters.
  // one pulse from idle, or a long period so arming lands between edges.
  always @(negedge ref_clk_i) begin
    phase_reg <= phase_reg + 4'h1;
    sync_o <= !sync_low_reg;
    sysref_o <= run_reg ? phase_reg[3] : shot_reg;
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the oscillator sync and decimation chain.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ddc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic signed [SAMPLE_W-1:0] sample_chan_a_i = 12'sh064, sample_chan_b_i = 12'sh064;
  logic [OSC_COUNT-1:0][FREQ_W-1:0] freq_word_chan_a_i = '0, freq_word_chan_b_i = '0;
  logic [OSC_COUNT-1:0][PHASE_OFS_W-1:0] phase_offset_chan_a_i = '0, phase_offset_chan_b_i = '0;
  logic [RDIV_W-1:0] rational_divisor_i = RDIV_BASIC;
  logic osc_select_source_i = 1'b0, link_sync_enable_i = 1'b0, next_sysref_arm_i = 1'b0;
  logic link_enable_i = 1'b0, encoding_64b66b_i = 1'b0;
  logic [SEL_W-1:0] osc_select_reg_a_i = '0, osc_select_reg_b_i = '0;
  logic [SEL_W-1:0] osc_select_pins_a_i = '0, osc_select_pins_b_i = '0;
  logic [2:0] decim_sel_i = DECIM_BYPASS;
  wire logic sync_i, sysref_i;
  logic sync_low = 1'b0, sysref_run = 1'b0, sysref_shot = 1'b0;
  logic out_valid_o, out_complex_o, sync_armed_o, phase_deterministic_o, nco_sync_pulse_o, code_group_sync_start_o;
  logic signed [OUT_W-1:0] out_i_chan_a_o, out_q_chan_a_o, out_i_chan_b_o, out_q_chan_b_o;
  int bad_count = 0, num_checks = 0, n_valid = 0, n_sync = 0, n_cgs = 0;
  nco_sync_and_decimation_chain nco_sync_and_decimation_chain_i (.*);
  rx_model rx_model_i (.ref_clk_i, .sync_low_i(sync_low), .sysref_run_i(sysref_run), .sysref_shot_i(sysref_shot),
    .sync_o(sync_i), .sysref_o(sysref_i));
  initial forever #25 ref_clk_i = ~ref_clk_i;
  // Pulse counters sample before the edge's updates land.
  always @(posedge ref_clk_i) begin
    n_valid += out_valid_o;
    n_sync += nco_sync_pulse_o;
    n_cgs += code_group_sync_start_o;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic zero();
    n_valid = 0;
    n_sync = 0;
    n_cgs = 0;
  endtask
  task automatic t_bypass();
    sample_chan_a_i = -12'sd5;
    cyc(4);
    chk(out_i_chan_a_o, -5);
    chk(out_q_chan_a_o, 0);
    chk(out_complex_o, 0);
    sample_chan_a_i = 12'sh064;
    $display("test bypass done");
  endtask
  // The DC input at zero frequency passes each stage at unity gain.
  task automatic t_rate();
    for (int m = 1; m <= 4; m++) begin
      decim_sel_i = 3'(m);
      cyc(400);
      zero();
      cyc(256);
      chk(n_valid, 256 >> (m + 1));
      chk(out_complex_o, 1);
    end
    chk(out_i_chan_a_o, 800);
    chk(out_q_chan_a_o, 0);
    $display("test rate done");
  endtask
  task automatic t_select();
    int e[4][2] = '{'{800, 0}, '{0, 800}, '{-800, 0}, '{0, -800}};
    decim_sel_i = DECIM_4;
    for (int k = 0; k < 4; k++) begin
      phase_offset_chan_a_i[k] = PHASE_OFS_W'(k * 16384);
      phase_offset_chan_b_i[k] = PHASE_OFS_W'(k * 16384);
    end
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 2; s++) begin
        osc_select_source_i = s[0];
        osc_select_reg_a_i = SEL_W'(s ? 3 - k : k);
        osc_select_reg_b_i = SEL_W'(s ? 3 - k : k);
        osc_select_pins_a_i = SEL_W'(s ? k : 3 - k);
        osc_select_pins_b_i = SEL_W'(s ? k : 3 - k);
        cyc(60);
        chk(s ? out_i_chan_b_o : out_i_chan_a_o, e[k][0]);
        chk(s ? out_q_chan_b_o : out_q_chan_a_o, e[k][1]);
      end
    end
    $display("test select done");
  endtask
  // The third pass leaves link sync off, so no sync may follow.
  task automatic t_link();
    for (int c = 0; c < 3; c++) begin
      encoding_64b66b_i = c[0];
      link_sync_enable_i = c < 2;
      link_enable_i = 1'b0;
      freq_word_chan_a_i[1] += 32'h01000000;
      cyc(4);
      chk(phase_deterministic_o, 0);
      link_enable_i = 1'b1;
      cyc(4);
      zero();
      sync_low = 1'b1;
      cyc(8);
      chk(n_cgs, !c[0]);
      sync_low = 1'b0;
      cyc(8);
      chk(n_sync, c < 2);
      chk(phase_deterministic_o, c < 2);
    end
    $display("test link done");
  endtask
  task automatic t_sysref();
    for (int r = 0; r < 2; r++) begin
      freq_word_chan_a_i[2] += 32'h00100000;
      next_sysref_arm_i = 1'b0;
      cyc(4);
      chk(phase_deterministic_o, 0);
      zero();
      next_sysref_arm_i = 1'b1;
      sysref_run = r[0];
      cyc(6);
      if (r == 0) begin
        chk(sync_armed_o, 1);
        chk(n_sync, 0);
        sysref_shot = 1'b1;
        cyc(1);
        sysref_shot = 1'b0;
      end
      cyc(40);
      chk(n_sync, 1);
      chk(sync_armed_o, 0);
      chk(phase_deterministic_o, 1);
      sysref_run = 1'b0;
    end
    $display("test sysref done");
  endtask
  // A third of the clock on a divisor of three closes one turn every three steps, so the mixer repeats exactly.
  // Without the snap the phase lands one code short and the sums of three outputs come out 34 and other values.
  task automatic t_rational();
    int got = 0;
    logic signed [31:0] sum_i = '0, sum_q = '0;
    osc_select_source_i = 1'b0;
    osc_select_reg_a_i = '0;
    rational_divisor_i = 16'h0003;
    freq_word_chan_a_i[0] = 32'h55555555;
    next_sysref_arm_i = 1'b0;
    cyc(4);
    next_sysref_arm_i = 1'b1;
    cyc(6);
    sysref_shot = 1'b1;
    cyc(1);
    sysref_shot = 1'b0;
    cyc(80);
    for (int n = 0; n < 16 && got < 3; n++) begin
      cyc(1);
      if (out_valid_o === 1'b1) begin
        got++;
        sum_i += out_i_chan_a_o;
        sum_q += out_q_chan_a_o;
      end
    end
    chk(got, 3);
    chk(sum_i, 50);
    chk(sum_q, 74);
    $display("test rational done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    cyc(20);
    nrst_i = 1'b1;
    t_bypass();
    t_rate();
    t_select();
    t_link();
    t_sysref();
    t_rational();
    wrap_up();
  end
  initial begin
    #500us;
    bad_count++;
    $display("mismatch at %0t: run hung", $time);
    wrap_up();
  end
endmodule
bind nco_sync_and_decimation_chain nco_chk nco_chk_i (.*);
`default_nettype wire
